// ==== hdl/hmc_pkg.sv ====
// Purpose: Shared constants and types for the haptic mode control block.
// Assumes: 100 MHz sys_clk, 8-bit register port driven by the serial slave.
// Notes:   Offsets, named bit positions, the reset cycle count and the standby, mode, sample and read data resets live here.
package hmc_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    // Length of the soft reset sequence, least time
    localparam int SOFT_RESET_TIME_NS = 100;
    localparam int RESET_CYCLES = (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RESET_CNT_LAST = 8'(RESET_CYCLES - 1);

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h01;
    localparam logic [7:0] ADDR_RTP = 8'h02;
    localparam logic [7:0] ADDR_GO = 8'h0c;
    localparam logic [7:0] ADDR_FORMAT = 8'h1d;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int MODE_RESET_BIT = 7;
    localparam int MODE_STANDBY_BIT = 6;
    localparam int STATUS_DIAG_BIT = 3;
    localparam int GO_BIT = 0;
    localparam int FMT_UNSIGNED_BIT = 3;
    localparam int FMT_AC_COUPLING_ENABLE_BIT = 1;
    localparam int FMT_ANALOG_BIT = 0;
    // Identity field in the status register; value is arbitrary
    localparam logic [2:0] DEVICE_ID = 3'h1;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic STANDBY_RST = 1'b1;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [7:0] RTP_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        HMC_MODE_INTERNAL = 3'h0,
        HMC_MODE_EDGE = 3'h1,
        HMC_MODE_LEVEL = 3'h2,
        HMC_MODE_PWM_ANALOG = 3'h3,
        HMC_MODE_AUDIO = 3'h4,
        HMC_MODE_REALTIME = 3'h5,
        HMC_MODE_DIAG = 3'h6,
        HMC_MODE_CALIB = 3'h7
    } hmc_mode_t;

    typedef enum logic {
        HMC_RST_IDLE = 1'b0,
        HMC_RST_HOLD = 1'b1
    } hmc_rst_state_t;

    // Everything the playback engine needs from this block
    typedef struct packed {
        logic go;
        logic cancel;
        logic abort;
        logic standby;
        hmc_mode_t mode;
        logic drive_active;
        logic analog_select;
        logic ac_coupling_enable;
        logic [8:0] drive_sample;
    } hmc_engine_t;

endpackage

// ==== hdl/hmc_trig_sync.sv ====
// Purpose: Brings the trigger pin into sys_clk and finds its edges.
// Assumes: Pin is asynchronous to sys_clk.
// Notes:   Edge pulses are one cycle, one to two cycles after the pin moves.
module hmc_trig_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;

    // ****************************************
    // Synchroniser and edge memory
    // ****************************************
    // First stage is read only by the second
    always_comb begin
        meta_d = pin;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (ce) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // Pulses qualified by ce so a frozen cycle never repeats an edge
    assign level = sync_q;
    assign rise = ce & sync_q & ~prev_q;
    assign fall = ce & ~sync_q & prev_q;
endmodule // hmc_trig_sync

// ==== hdl/hmc_mode_ctrl.sv ====
// Purpose: Mode control register bank and go/trigger logic of a haptic driver.
// Assumes: Register port comes from the serial slave on sys_clk; engine on sys_clk.
// Notes:   Read data returns one cycle after reg_rd.
// What this block does
// - Writing one to mode bit 7 stops playback and restores all register defaults.
// - The soft reset bit clears itself when the reset sequence has finished.
// - Mode bit 6 is software standby, default one; zero means ready.
// - Mode field bits 2-0 default zero; zero fires waveforms only by software go.
// - Mode one: a rising trigger pin edge sets go.
// - Mode one: a second rising edge while go is set cancels the waveform.
// - Mode two: rising edge sets go, falling edge sends a cancel.
// - Mode two: an edge that leaves go unchanged does nothing.
// - Mode three: drive the actuator from the trigger pin signal continuously.
// - Mode three: analog select bit picks PWM or analog pin input.
// - Mode five: continuously drive the actuator with the realtime sample register.
// - Mode six: go starts diagnostics; device clears go and stores the result.
// - Mode seven: go starts calibration; device clears go when it completes.
// - Result flag holds the last routine outcome and clears when read.
// - Realtime sample is signed unless the format bit selects unsigned.
module hmc_mode_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic input_trigger_pin,
    input wire logic engine_done,
    input wire logic routine_fail,
    output hmc_pkg::hmc_engine_t engine
);
    localparam int RST_LAST = hmc_pkg::RESET_CYCLES;

    // ****************************************
    // State
    // ****************************************
    hmc_pkg::hmc_rst_state_t rst_state_q, rst_state_d;
    logic [7:0] rst_cnt_q, rst_cnt_d;
    logic standby_q, standby_d;
    hmc_pkg::hmc_mode_t mode_q, mode_d;
    logic [7:0] rtp_q, rtp_d;
    logic go_q, go_d;
    logic cancel_q, cancel_d;
    logic fmt_unsigned_q, fmt_unsigned_d;
    logic ac_coupling_enable_q, ac_coupling_enable_d;
    logic analog_sel_q, analog_sel_d;
    logic diag_q, diag_d;
    logic [7:0] rdata_q, rdata_d;

    logic trig_rise, trig_fall;
    logic in_reset, rst_req, go_wr, stat_rd, routine_mode;

    hmc_trig_sync u_trig_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin(input_trigger_pin),
        .level(),
        .rise(trig_rise),
        .fall(trig_fall)
    );

    // ****************************************
    // Decode
    // ****************************************
    assign in_reset = (rst_state_q == hmc_pkg::HMC_RST_HOLD);
    assign rst_req = reg_wr && (reg_addr == hmc_pkg::ADDR_MODE) && reg_wdata[hmc_pkg::MODE_RESET_BIT];
    assign go_wr = reg_wr && (reg_addr == hmc_pkg::ADDR_GO);
    assign stat_rd = reg_rd && (reg_addr == hmc_pkg::ADDR_STATUS);
    assign routine_mode = (mode_q == hmc_pkg::HMC_MODE_DIAG) || (mode_q == hmc_pkg::HMC_MODE_CALIB);

    // ****************************************
    // Soft reset sequencer
    // ****************************************
    // Bit reads one while the count runs, then drops by itself
    always_comb begin
        rst_state_d = rst_state_q;
        rst_cnt_d = rst_cnt_q;
        unique case (rst_state_q)
            hmc_pkg::HMC_RST_IDLE: begin
                if (rst_req) begin
                    rst_state_d = hmc_pkg::HMC_RST_HOLD;
                    rst_cnt_d = hmc_pkg::RESET_CNT_LAST;
                end
            end
            hmc_pkg::HMC_RST_HOLD: begin
                if (rst_cnt_q == 8'h00) begin
                    rst_state_d = hmc_pkg::HMC_RST_IDLE;
                end else begin
                    rst_cnt_d = rst_cnt_q - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rst_state_q <= hmc_pkg::HMC_RST_IDLE;
            rst_cnt_q <= 8'h00;
        end else if (ce) begin
            rst_state_q <= rst_state_d;
            rst_cnt_q <= rst_cnt_d;
        end
    end

    // ****************************************
    // Register bank and go control
    // ****************************************
    // Order matters: done clears first, then writes, then pin events,
    // so the later step wins in the same cycle, even when a pin event clears a go that a write set.
    always_comb begin
        standby_d = standby_q;
        mode_d = mode_q;
        rtp_d = rtp_q;
        go_d = go_q;
        cancel_d = 1'b0;
        fmt_unsigned_d = fmt_unsigned_q;
        ac_coupling_enable_d = ac_coupling_enable_q;
        analog_sel_d = analog_sel_q;
        diag_d = diag_q;
        if (in_reset || rst_req) begin
            // Playback interrupted at once, all fields back to defaults
            standby_d = hmc_pkg::STANDBY_RST;
            mode_d = hmc_pkg::hmc_mode_t'(hmc_pkg::MODE_RST);
            rtp_d = hmc_pkg::RTP_RST;
            go_d = 1'b0;
            fmt_unsigned_d = 1'b0;
            ac_coupling_enable_d = 1'b0;
            analog_sel_d = 1'b0;
            diag_d = 1'b0;
        end else begin
            // Read of status clears the flag; a completion below wins
            if (stat_rd) begin
                diag_d = 1'b0;
            end
            // Engine finished or cancelled: go drops by itself
            if (engine_done && go_q) begin
                go_d = 1'b0;
                if (routine_mode) begin
                    diag_d = routine_fail;
                end
            end
            if (reg_wr) begin
                unique case (reg_addr)
                    hmc_pkg::ADDR_MODE: begin
                        standby_d = reg_wdata[hmc_pkg::MODE_STANDBY_BIT];
                        mode_d = hmc_pkg::hmc_mode_t'(reg_wdata[2:0]);
                    end
                    hmc_pkg::ADDR_RTP: rtp_d = reg_wdata;
                    hmc_pkg::ADDR_GO: begin
                        // Software go starts internal, diagnostic and calibration runs
                        go_d = reg_wdata[hmc_pkg::GO_BIT];
                        cancel_d = go_q && !reg_wdata[hmc_pkg::GO_BIT];
                    end
                    hmc_pkg::ADDR_FORMAT: begin
                        fmt_unsigned_d = reg_wdata[hmc_pkg::FMT_UNSIGNED_BIT];
                        ac_coupling_enable_d = reg_wdata[hmc_pkg::FMT_AC_COUPLING_ENABLE_BIT];
                        analog_sel_d = reg_wdata[hmc_pkg::FMT_ANALOG_BIT];
                    end
                    default: ;
                endcase
            end
            // Pin events in the two external trigger modes
            if (mode_q == hmc_pkg::HMC_MODE_EDGE && trig_rise) begin
                if (go_q) begin
                    go_d = 1'b0;
                    cancel_d = 1'b1;
                end else begin
                    go_d = 1'b1;
                end
            end
            if (mode_q == hmc_pkg::HMC_MODE_LEVEL) begin
                // Edges that match the current go state fall through untouched
                if (trig_rise && !go_q) begin
                    go_d = 1'b1;
                end
                if (trig_fall && go_q) begin
                    go_d = 1'b0;
                    cancel_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            standby_q <= hmc_pkg::STANDBY_RST;
            mode_q <= hmc_pkg::HMC_MODE_INTERNAL;
            rtp_q <= hmc_pkg::RTP_RST;
            go_q <= 1'b0;
            cancel_q <= 1'b0;
            fmt_unsigned_q <= 1'b0;
            ac_coupling_enable_q <= 1'b0;
            analog_sel_q <= 1'b0;
            diag_q <= 1'b0;
        end else if (ce) begin
            standby_q <= standby_d;
            mode_q <= mode_d;
            rtp_q <= rtp_d;
            go_q <= go_d;
            cancel_q <= cancel_d;
            fmt_unsigned_q <= fmt_unsigned_d;
            ac_coupling_enable_q <= ac_coupling_enable_d;
            analog_sel_q <= analog_sel_d;
            diag_q <= diag_d;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Registered so the serial slave sees stable data; unmapped reads zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                hmc_pkg::ADDR_STATUS: rdata_d = {hmc_pkg::DEVICE_ID, 1'b0, diag_q, 3'h0};
                hmc_pkg::ADDR_MODE: rdata_d = {in_reset, standby_q, 3'h0, mode_q};
                hmc_pkg::ADDR_RTP: rdata_d = rtp_q;
                hmc_pkg::ADDR_GO: rdata_d = {7'h00, go_q};
                hmc_pkg::ADDR_FORMAT: rdata_d = {4'h0, fmt_unsigned_q, 1'b0, ac_coupling_enable_q, analog_sel_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_q <= hmc_pkg::RDATA_RST;
        end else if (ce) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************
    // Engine outputs
    // ****************************************
    // Modes 3, 4 and 5 drive the actuator while ready; pin modes use analog select
    assign engine.go = go_q;
    assign engine.cancel = cancel_q;
    assign engine.abort = in_reset;
    assign engine.standby = standby_q;
    assign engine.mode = mode_q;
    assign engine.drive_active = !standby_q && !in_reset &&
        (mode_q == hmc_pkg::HMC_MODE_PWM_ANALOG || mode_q == hmc_pkg::HMC_MODE_AUDIO ||
         mode_q == hmc_pkg::HMC_MODE_REALTIME);
    assign engine.analog_select = analog_sel_q;
    assign engine.ac_coupling_enable = ac_coupling_enable_q;
    // Unsigned samples get a zero sign bit, signed ones are extended
    assign engine.drive_sample = fmt_unsigned_q ? {1'b0, rtp_q} : {rtp_q[7], rtp_q};

    // ****************************************
    // Assertions
    // ****************************************
    a_soft_reset_defaults: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && rst_req && !in_reset) |=> (in_reset && standby_q && !go_q && mode_q == hmc_pkg::HMC_MODE_INTERNAL))
        else $error("soft reset did not restore defaults");

    a_reset_self_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && $rose(in_reset)) |-> ##[1:RST_LAST] !in_reset)
        else $error("soft reset bit did not self clear");

    a_standby_in_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        in_reset |-> (standby_q && engine.abort && !engine.drive_active))
        else $error("standby not forced during soft reset");

    a_software_go_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && !in_reset && !rst_req && go_wr && reg_wdata[0] && mode_q == hmc_pkg::HMC_MODE_INTERNAL)
        |=> go_q)
        else $error("software go not taken");

    a_edge_sets_go: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!in_reset && !rst_req && trig_rise && !go_q && mode_q == hmc_pkg::HMC_MODE_EDGE) |=> go_q)
        else $error("edge trigger did not set go");

    a_edge_cancels_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!in_reset && !rst_req && trig_rise && go_q && mode_q == hmc_pkg::HMC_MODE_EDGE)
        |=> (!go_q && engine.cancel))
        else $error("second edge did not cancel");

    a_level_no_change: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && !in_reset && !rst_req && !go_wr && trig_fall && !go_q && mode_q == hmc_pkg::HMC_MODE_LEVEL)
        |=> (!go_q && !engine.cancel))
        else $error("level edge changed idle go state");

    a_realtime_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode_q == hmc_pkg::HMC_MODE_REALTIME && !standby_q && !in_reset)
        |-> (engine.drive_active && engine.drive_sample[7:0] == rtp_q))
        else $error("realtime sample not driven");

    a_diagnostic_outcome_flag_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && !in_reset && !rst_req && !go_wr && engine_done && go_q && mode_q == hmc_pkg::HMC_MODE_DIAG)
        |=> (!go_q && diag_q == $past(routine_fail)))
        else $error("diagnostic end not recorded");

    a_result_read_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && !in_reset && !rst_req && stat_rd && !(engine_done && go_q)) |=> !diag_q)
        else $error("result flag not cleared by read");
endmodule // hmc_mode_ctrl

// ==== tb/hmc_engine_model.sv ====
// Purpose: Playback engine stand-in that answers the go bit of the mode block.
// Assumes: Same sys_clk as the block; go seen as a level.
// Notes:   Done is a one-cycle pulse; the fail line toggles outside it.
module hmc_engine_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic en,
    input wire logic [7:0] delay,
    input wire logic fail_value,
    output logic engine_done,
    output logic routine_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;

    // Finish a routine a set time after go; stays silent while disabled
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !go || !en) begin
            cnt_q <= 8'h00;
            engine_done <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            engine_done <= (cnt_q == delay);
        end
        // Outcome only means something beside done, so scramble it elsewhere
        routine_fail <= (rst_n && go && en && cnt_q == delay) ? fail_value : ~routine_fail;
    end
endmodule // hmc_engine_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the haptic mode control register block.
// Assumes: ce high except one freeze case; engine side played by hmc_engine_model.
// Notes:   Inputs change 1 ns after the rising edge; each access leaves one idle cycle.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} hmc_row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic pin = 1'b0;
    logic en = 1'b0;
    logic fail_value = 1'b0;
    logic engine_done;
    logic routine_fail;
    hmc_pkg::hmc_engine_t engine;
    int n_mismatch = 0;
    int checked = 0;
    int n_cancel = 0;
    int abort_cycles = 0;
    int c0;
    localparam logic [7:0] ST_OK = {hmc_pkg::DEVICE_ID, 5'h00};
    localparam logic [7:0] ST_FAIL = {hmc_pkg::DEVICE_ID, 5'h08};
    hmc_row_t rows [8] = '{
        '{8'h01, 8'h05, 8'h05}, '{8'h01, 8'h3f, 8'h07}, '{8'h01, 8'h46, 8'h46},
        '{8'h02, 8'h80, 8'h80}, '{8'h1d, 8'h0b, 8'h0b}, '{8'h1d, 8'h00, 8'h00},
        '{8'h00, 8'hff, ST_OK}, '{8'h03, 8'hff, 8'h00}};

    hmc_mode_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .input_trigger_pin(pin),
        .engine_done(engine_done), .routine_fail(routine_fail), .engine(engine));
    hmc_engine_model u_eng (.sys_clk(sys_clk), .rst_n(rst_n), .go(engine.go), .en(en), .delay(8'h04),
        .fail_value(fail_value), .engine_done(engine_done), .routine_fail(routine_fail));

    // ****************************************
    // Clock and monitors
    // ****************************************
    always #5 sys_clk = ~sys_clk;
    // Cancel and abort are short pulses, so count them at every edge
    always @(posedge sys_clk) begin
        if (engine.cancel === 1'b1) n_cancel++;
        if (engine.abort === 1'b1) abort_cycles++;
    end
    // Last-resort guard against a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        results();
    end

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    // Idle cycle after each access so a strobe never rises in the step it fell
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        chk8($sformatf("reg %h", a), exp, reg_rdata);
        tick();
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk9(input string what, input logic [8:0] exp, input logic [8:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkn(input string what, input int exp, input int got);
        checked++;
        if (got != exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // Bounded wait for the go bit; running out ends the run
    task automatic wait_go(input logic v, input int lim);
        int i;
        i = 0;
        while (engine.go !== v && i < lim) begin
            tick();
            i++;
        end
        chk8("go", {7'h00, v}, {7'h00, engine.go});
        if (engine.go !== v) results();
    endtask
    task automatic pin_to(input logic v);
        pin = v;
        repeat (4) tick();
    endtask
    task automatic results;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) tick();
        rst_n = 1'b1;
        // Defaults after power-up
        rd(8'h01, 8'h40);
        rd(8'h00, ST_OK);
        rd(8'h02, 8'h00);
        rd(8'h0c, 8'h00);
        chk8("standby", 8'h01, {7'h00, engine.standby});
        // Register table: write then read back
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rexp);
        end
        // Every mode with the device ready
        for (int m = 0; m < 8; m++) begin
            wr(8'h01, {5'h00, 3'(m)});
            chk8("mode", 8'(m), {5'h00, engine.mode});
            chk8("drive", {7'h00, 1'(m >= 3 && m <= 5)}, {7'h00, engine.drive_active});
        end
        wr(8'h01, 8'h45);
        chk8("drive standby", 8'h00, {7'h00, engine.drive_active});
        wr(8'h02, 8'h80);
        chk9("sample signed", 9'h180, engine.drive_sample);
        wr(8'h1d, 8'h08);
        chk9("sample unsigned", 9'h080, engine.drive_sample);
        wr(8'h1d, 8'h01);
        chk8("analog", 8'h01, {7'h00, engine.analog_select});
        wr(8'h1d, 8'h02);
        chk8("ac", 8'h01, {7'h00, engine.ac_coupling_enable});
        // Software go in internal mode, cleared by the engine
        en = 1'b1;
        wr(8'h01, 8'h00);
        wr(8'h0c, 8'h01);
        chk8("go set", 8'h01, {7'h00, engine.go});
        wait_go(1'b0, 20);
        // Diagnostic fail, then calibration pass: flag shows the last one
        fail_value = 1'b1;
        wr(8'h01, 8'h06);
        wr(8'h0c, 8'h01);
        wait_go(1'b0, 20);
        fail_value = 1'b0;
        // Calibration inputs live outside this block, so they count as programmed
        wr(8'h01, 8'h07);
        wr(8'h0c, 8'h01);
        wait_go(1'b0, 20);
        rd(8'h00, ST_OK);
        fail_value = 1'b1;
        wr(8'h01, 8'h06);
        wr(8'h0c, 8'h01);
        wait_go(1'b0, 20);
        rd(8'h00, ST_FAIL);
        rd(8'h00, ST_OK);
        // Edge trigger: second rise cancels
        en = 1'b0;
        wr(8'h01, 8'h01);
        c0 = n_cancel;
        pin = 1'b1;
        wait_go(1'b1, 8);
        pin_to(1'b0);
        pin = 1'b1;
        wait_go(1'b0, 8);
        // Monitor counts the cancel pulse one edge later
        tick();
        chkn("edge cancels", c0 + 1, n_cancel);
        pin_to(1'b0);
        // Level trigger follows the pin; matching edge does nothing
        wr(8'h01, 8'h02);
        pin = 1'b1;
        wait_go(1'b1, 8);
        pin = 1'b0;
        wait_go(1'b0, 8);
        wr(8'h0c, 8'h01);
        c0 = n_cancel;
        pin_to(1'b1);
        chk8("go held", 8'h01, {7'h00, engine.go});
        chkn("no cancel", c0, n_cancel);
        pin = 1'b0;
        wait_go(1'b0, 8);
        tick();
        chkn("level cancel", c0 + 1, n_cancel);
        // Falling pin while go is already clear must do nothing
        pin_to(1'b1);
        wr(8'h0c, 8'h00);
        c0 = n_cancel;
        pin_to(1'b0);
        chk8("go idle", 8'h00, {7'h00, engine.go});
        chkn("idle fall", c0, n_cancel);
        // PWM mode ignores pin edges for go
        wr(8'h01, 8'h03);
        pin_to(1'b1);
        chk8("go pwm", 8'h00, {7'h00, engine.go});
        pin_to(1'b0);
        // Soft reset in mid-playback
        wr(8'h01, 8'h05);
        wr(8'h02, 8'h55);
        wr(8'h0c, 8'h01);
        abort_cycles = 0;
        wr(8'h01, 8'h80);
        chk8("abort", 8'h01, {7'h00, engine.abort});
        chk8("go stop", 8'h00, {7'h00, engine.go});
        wr(8'h02, 8'h33);
        rd(8'h01, 8'hc0);
        for (int i = 0; i < 30 && engine.abort === 1'b1; i++) tick();
        chk8("abort end", 8'h00, {7'h00, engine.abort});
        chkn("reset length", hmc_pkg::RESET_CYCLES, abort_cycles);
        rd(8'h01, 8'h40);
        rd(8'h02, 8'h00);
        rd(8'h0c, 8'h00);
        // Frozen clock enable: a write must not land
        ce = 1'b0;
        wr(8'h02, 8'haa);
        ce = 1'b1;
        rd(8'h02, 8'h00);
        results();
    end
endmodule // testbench
